// *** design/acl_pkg.sv ***
// Shared constants, register layouts and carrier types of the ACL classifier.
// Assumes one core clock; software reaches the block over AXI4-Lite.
package acl_pkg;

	// ----------------------------------------------------------------
	// Sizes and register map
	// ----------------------------------------------------------------
	localparam int NUM_PORTS = 12;
	localparam int PORT_W = 4;
	localparam int ADDR_W = 16;
	localparam logic [15:0] DEF2_ACT_OFS = 16'h0000;
	localparam logic [15:0] CPU_READY_OFS = 16'h0004;
	localparam logic [15:0] STATUS_OFS = 16'h0008;
	localparam logic [7:0] PORT_CFG_PAGE = 8'h01;
	localparam logic [7:0] PORT_ACT_PAGE = 8'h02;
	localparam logic [1:0] ENTRY_REGION = 2'h1;
	localparam logic CPU_READY_RST = 1'b0;

	// ----------------------------------------------------------------
	// Register decode kinds and bus answers
	// ----------------------------------------------------------------
	localparam logic [2:0] KIND_NONE = 3'h0;
	localparam logic [2:0] KIND_DEF2 = 3'h1;
	localparam logic [2:0] KIND_CPURDY = 3'h2;
	localparam logic [2:0] KIND_STATUS = 3'h3;
	localparam logic [2:0] KIND_PCFG = 3'h4;
	localparam logic [2:0] KIND_PACT = 3'h5;
	localparam logic [2:0] KIND_ENTRY = 3'h6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// ARP sanity constants
	// ----------------------------------------------------------------
	localparam logic [15:0] ARP_HW_ETH = 16'h0001;
	localparam logic [15:0] ARP_PROTO_IP = 16'h0800;
	localparam logic [7:0] ARP_HW_LEN = 8'h06;
	localparam logic [7:0] ARP_PROTO_LEN = 8'h04;

	// ----------------------------------------------------------------
	// Register word layouts
	// ----------------------------------------------------------------
	typedef struct packed {
		logic rsvd;
		logic [7:0] pagVal;
		logic pagEna;
		logic [2:0] classVal;
		logic classEna;
		logic [2:0] cpuQueue;
		logic cpuCopy;
		logic singleShot;
		logic maskMode;
		logic [NUM_PORTS-1:0] egressMask;
	} action_s;

	typedef struct packed {
		logic [NUM_PORTS-1:0] portMask;
		logic [6:0] rsvd;
		logic arpCheck;
		logic [7:0] pagVal;
		logic pagCare;
		logic second;
		logic accessStage;
		logic valid;
	} ctrl_s;

	typedef struct packed {
		logic [20:0] rsvd;
		logic [2:0] defClass;
		logic [7:0] defPag;
	} port_cfg_s;

	// Word 0 key value, 1 key care mask, 2 control, 3 action
	typedef struct packed {
		action_s act;
		ctrl_s ctrl;
		logic [31:0] keyMask;
		logic [31:0] keyVal;
	} entry_s;

	// ----------------------------------------------------------------
	// Frame pipeline carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] keyWord;
		logic [PORT_W-1:0] port;
		logic dmacBcast;
		logic [15:0] arpHwType;
		logic [15:0] arpProtoType;
		logic [7:0] arpHwLen;
		logic [7:0] arpProtoLen;
		logic [47:0] arpSha;
		logic [47:0] smac;
	} frame_s;

	typedef struct packed {
		logic valid;
		logic hit1;
		logic hit2;
		logic discard;
		logic maskMode;
		logic [NUM_PORTS-1:0] egressMask;
		logic cpuCopy;
		logic [2:0] cpuQueue;
		logic [2:0] qosClass;
		logic [7:0] pag;
	} result_s;

endpackage : acl_pkg

// *** design/acl_tcam_classifier.sv ***
// Ternary ACL classifier: first-stage class/tag lookup, then two
// access-stage lookups with per-port and common default actions.
// Assumes frame requests come from logic on clk; registers over AXI4-Lite.
module acl_tcam_classifier #(
	parameter int NUM_ENTRIES = 512
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [acl_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [acl_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic frameValid,
	input wire acl_pkg::frame_s frameIn,
	output logic frameReady,
	output acl_pkg::result_s result
);

	localparam int IDX_W = $clog2(NUM_ENTRIES);
	localparam int NP = acl_pkg::NUM_PORTS;
	localparam int PORT_W_L = acl_pkg::PORT_W;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_FIRST = 2'b01,
		PH_ACCESS = 2'b10
	} phase_e;

	typedef struct packed {
		phase_e phase;
		acl_pkg::frame_s frm;
		logic [7:0] pag;
		logic [2:0] cls;
		acl_pkg::result_s res;
		logic frameReady;
		logic awGot;
		logic wGot;
		logic [acl_pkg::ADDR_W-1:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic cpuReady;
		acl_pkg::action_s def2;
		acl_pkg::port_cfg_s [NP-1:0] portCfg;
		acl_pkg::action_s [NP-1:0] portAct;
		acl_pkg::entry_s [NUM_ENTRIES-1:0] entries;
	} state_s;

	state_s state_r;
	state_s state_nxt;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [2:0] regKind(
		input logic [acl_pkg::ADDR_W-1:0] a
	);
		logic [2:0] k;
		k = acl_pkg::KIND_NONE;
		if (a[1:0] != 2'h0) begin
			k = acl_pkg::KIND_NONE;
		end else if (a[15:14] == acl_pkg::ENTRY_REGION) begin
			if ({1'b0, a[13:4]} < 11'(NUM_ENTRIES)) begin
				k = acl_pkg::KIND_ENTRY;
			end
		end else if (a == acl_pkg::DEF2_ACT_OFS) begin
			k = acl_pkg::KIND_DEF2;
		end else if (a == acl_pkg::CPU_READY_OFS) begin
			k = acl_pkg::KIND_CPURDY;
		end else if (a == acl_pkg::STATUS_OFS) begin
			k = acl_pkg::KIND_STATUS;
		end else if (a[7:6] == 2'h0 && a[5:2] < 4'(NP)) begin
			if (a[15:8] == acl_pkg::PORT_CFG_PAGE) begin
				k = acl_pkg::KIND_PCFG;
			end else if (a[15:8] == acl_pkg::PORT_ACT_PAGE) begin
				k = acl_pkg::KIND_PACT;
			end
		end
		return k;
	endfunction : regKind

	function automatic logic [31:0] mergeStrb(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0] strb
	);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				m[8*b +: 8] = data[8*b +: 8];
			end
		end
		return m;
	endfunction : mergeStrb

	function automatic logic entryHit(
		input acl_pkg::entry_s e,
		input acl_pkg::frame_s f,
		input logic [7:0] pag,
		input logic accessLookup,
		input logic secondLookup,
		input logic arpOk
	);
		logic h;
		h = e.ctrl.valid && ((f.keyWord ^ e.keyVal) & e.keyMask) == 32'h0;
		h = h && (e.ctrl.accessStage == accessLookup);
		if (accessLookup) begin
			h = h && (e.ctrl.second == secondLookup);
		end
		h = h && e.ctrl.portMask[f.port];
		h = h && (!e.ctrl.pagCare || e.ctrl.pagVal == pag);
		h = h && (!e.ctrl.arpCheck || arpOk);
		return h;
	endfunction : entryHit

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic arpOk;
		logic hitA;
		logic hitB;
		logic hitC;
		logic [IDX_W-1:0] selA;
		logic [IDX_W-1:0] selB;
		logic [IDX_W-1:0] selC;
		acl_pkg::action_s act1;
		acl_pkg::action_s act2;
		acl_pkg::action_s fs;
		logic [NP-1:0] mask;
		logic copy1;
		logic shot;
		logic [IDX_W-1:0] eIdx;
		logic [PORT_W_L-1:0] pIdx;
		logic [2:0] wKind;
		logic [2:0] rKind;
		logic [IDX_W-1:0] rIdx;
		logic [31:0] rWord;
		arpOk = 1'b0;
		hitA = 1'b0;
		hitB = 1'b0;
		hitC = 1'b0;
		selA = '0;
		selB = '0;
		selC = '0;
		act1 = '0;
		act2 = '0;
		fs = '0;
		mask = '0;
		copy1 = 1'b0;
		shot = 1'b0;
		eIdx = '0;
		pIdx = '0;
		wKind = acl_pkg::KIND_NONE;
		rKind = acl_pkg::KIND_NONE;
		rIdx = '0;
		rWord = 32'h0;
		state_nxt = state_r;
		state_nxt.res.valid = 1'b0;

		arpOk = state_r.frm.dmacBcast &&
			state_r.frm.arpHwType == acl_pkg::ARP_HW_ETH &&
			state_r.frm.arpProtoType == acl_pkg::ARP_PROTO_IP &&
			state_r.frm.arpHwLen == acl_pkg::ARP_HW_LEN &&
			state_r.frm.arpProtoLen == acl_pkg::ARP_PROTO_LEN &&
			state_r.frm.arpSha == state_r.frm.smac;

		for (int i = 0; i < NUM_ENTRIES; i++) begin
			if (entryHit(state_r.entries[i], state_r.frm, state_r.pag,
					1'b0, 1'b0, arpOk)) begin
				hitA = 1'b1;
				selA = IDX_W'(i);
			end
			// all three list kinds searched at once
			if (entryHit(state_r.entries[i], state_r.frm, state_r.pag,
					1'b1, 1'b0, arpOk)) begin
				hitB = 1'b1;
				selB = IDX_W'(i);
			end
			if (entryHit(state_r.entries[i], state_r.frm, state_r.pag,
					1'b1, 1'b1, arpOk)) begin
				hitC = 1'b1;
				selC = IDX_W'(i);
			end
		end

		case (state_r.phase)
			PH_IDLE: begin
				if (frameValid && state_r.frameReady) begin
					state_nxt.frm = frameIn;
					state_nxt.pag = state_r.portCfg[frameIn.port].defPag;
					state_nxt.cls = state_r.portCfg[frameIn.port].defClass;
					state_nxt.frameReady = 1'b0;
					state_nxt.phase = PH_FIRST;
				end
			end
			PH_FIRST: begin
				fs = state_r.entries[selA].act;
				if (hitA && fs.pagEna) begin
					state_nxt.pag = fs.pagVal;
				end
				if (hitA && fs.classEna) begin
					state_nxt.cls = fs.classVal;
				end
				state_nxt.phase = PH_ACCESS;
			end
			PH_ACCESS: begin
				act1 = hitB ? state_r.entries[selB].act :
					state_r.portAct[state_r.frm.port];
				act2 = hitC ? state_r.entries[selC].act : state_r.def2;
				mask = {NP{1'b1}};
				if (act1.maskMode) begin
					mask = mask & act1.egressMask;
				end
				if (act2.maskMode) begin
					mask = mask & act2.egressMask;
				end
				shot = (act1.singleShot || act2.singleShot) &&
					state_r.cpuReady;
				copy1 = act1.cpuCopy || (act1.singleShot && state_r.cpuReady);
				if (shot) begin
					state_nxt.cpuReady = 1'b0;
				end
				state_nxt.res.valid = 1'b1;
				state_nxt.res.hit1 = hitB;
				state_nxt.res.hit2 = hitC;
				state_nxt.res.maskMode = act1.maskMode || act2.maskMode;
				state_nxt.res.egressMask = mask;
				// zero mask in mask mode discards
				// discard does not stop the CPU copy
				state_nxt.res.discard = (act1.maskMode || act2.maskMode) &&
					mask == '0;
				state_nxt.res.cpuCopy = act1.cpuCopy || act2.cpuCopy || shot;
				state_nxt.res.cpuQueue = copy1 ? act1.cpuQueue :
					act2.cpuQueue;
				state_nxt.res.qosClass = state_r.cls;
				state_nxt.res.pag = state_r.pag;
				state_nxt.frameReady = 1'b1;
				state_nxt.phase = PH_IDLE;
			end
			default: begin
				state_nxt.phase = PH_IDLE;
				state_nxt.frameReady = 1'b1;
			end
		endcase

		// ------------------------------------------------------------
		// AXI4-Lite write channel
		// ------------------------------------------------------------
		if (awvalid && state_r.awready) begin
			state_nxt.awGot = 1'b1;
			state_nxt.awAddr = awaddr;
		end
		if (wvalid && state_r.wready) begin
			state_nxt.wGot = 1'b1;
			state_nxt.wData = wdata;
			state_nxt.wStrb = wstrb;
		end
		if (state_r.bvalid && bready) begin
			state_nxt.bvalid = 1'b0;
		end
		if (state_r.awGot && state_r.wGot && !state_r.bvalid) begin
			wKind = regKind(state_r.awAddr);
			eIdx = state_r.awAddr[4 +: IDX_W];
			pIdx = state_r.awAddr[2 +: PORT_W_L];
			state_nxt.awGot = 1'b0;
			state_nxt.wGot = 1'b0;
			state_nxt.bvalid = 1'b1;
			state_nxt.bresp = acl_pkg::RESP_OKAY;
			// byte lanes left unstrobed keep their stored value
			case (wKind)
				acl_pkg::KIND_DEF2: begin
					state_nxt.def2 = mergeStrb(state_r.def2,
						state_r.wData, state_r.wStrb);
				end
				acl_pkg::KIND_CPURDY: begin
					// Software set lands after the hardware clear
					if (state_r.wStrb[0] && state_r.wData[0]) begin
						state_nxt.cpuReady = 1'b1;
					end
				end
				acl_pkg::KIND_STATUS: begin
				end
				acl_pkg::KIND_PCFG: begin
					state_nxt.portCfg[pIdx] = mergeStrb(
						state_r.portCfg[pIdx], state_r.wData,
						state_r.wStrb);
				end
				acl_pkg::KIND_PACT: begin
					state_nxt.portAct[pIdx] = mergeStrb(
						state_r.portAct[pIdx], state_r.wData,
						state_r.wStrb);
				end
				acl_pkg::KIND_ENTRY: begin
					state_nxt.entries[eIdx][{state_r.awAddr[3:2], 5'h00}
						+: 32] = mergeStrb(state_r.entries[eIdx][
						{state_r.awAddr[3:2], 5'h00} +: 32],
						state_r.wData, state_r.wStrb);
				end
				default: begin
					state_nxt.bresp = acl_pkg::RESP_SLVERR;
				end
			endcase
		end
		state_nxt.awready = !state_nxt.awGot && !state_nxt.bvalid;
		state_nxt.wready = !state_nxt.wGot && !state_nxt.bvalid;

		// ------------------------------------------------------------
		// AXI4-Lite read channel
		// ------------------------------------------------------------
		if (state_r.rvalid && rready) begin
			state_nxt.rvalid = 1'b0;
			state_nxt.arready = 1'b1;
		end
		if (arvalid && state_r.arready) begin
			rKind = regKind(araddr);
			rIdx = araddr[4 +: IDX_W];
			pIdx = araddr[2 +: PORT_W_L];
			state_nxt.rresp = acl_pkg::RESP_OKAY;
			case (rKind)
				acl_pkg::KIND_DEF2: rWord = state_r.def2;
				acl_pkg::KIND_CPURDY: rWord = {31'h0, state_r.cpuReady};
				acl_pkg::KIND_STATUS: begin
					rWord = {28'h0, state_r.res.hit2, state_r.res.hit1,
						state_r.phase != PH_IDLE, state_r.cpuReady};
				end
				acl_pkg::KIND_PCFG: rWord = state_r.portCfg[pIdx];
				acl_pkg::KIND_PACT: rWord = state_r.portAct[pIdx];
				acl_pkg::KIND_ENTRY: begin
					rWord = state_r.entries[rIdx][{araddr[3:2], 5'h00} +: 32];
				end
				default: begin
					rWord = 32'h0;
					state_nxt.rresp = acl_pkg::RESP_SLVERR;
				end
			endcase
			state_nxt.rdata = rWord;
			state_nxt.rvalid = 1'b1;
			state_nxt.arready = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= '0;
			state_r.phase <= PH_IDLE;
			state_r.frameReady <= 1'b1;
			state_r.awready <= 1'b1;
			state_r.wready <= 1'b1;
			state_r.arready <= 1'b1;
			state_r.cpuReady <= acl_pkg::CPU_READY_RST;
		end else if (ce) begin
			state_r <= state_nxt;
		end
	end

	assign awready = state_r.awready;
	assign wready = state_r.wready;
	assign bvalid = state_r.bvalid;
	assign bresp = state_r.bresp;
	assign arready = state_r.arready;
	assign rvalid = state_r.rvalid;
	assign rdata = state_r.rdata;
	assign rresp = state_r.rresp;
	assign frameReady = state_r.frameReady;
	assign result = state_r.res;

endmodule : acl_tcam_classifier

// *** sim/acl_tcam_classifier_props.sv ***
// Port-level checks of the ACL classifier.
// Assumes one clk domain, synchronous active-high rst, bound to the top.
module acl_tcam_classifier_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic frameValid,
	input wire logic frameReady,
	input wire acl_pkg::result_s result
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Frame path
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst || !ce);
	logic take;
	assign take = frameValid && frameReady;

	chk_frame_latency:
	assert property (take |-> ##3 result.valid)
		else $error("result not three cycles after take");
	chk_ready_drop:
	assert property (take |=> !frameReady ##1 !frameReady)
		else $error("frame ready during lookup");
	chk_ready_back:
	assert property ($rose(frameReady) |-> result.valid)
		else $error("frame ready rose without result");
	chk_valid_pulse:
	assert property (result.valid |=> !result.valid)
		else $error("result valid longer than one cycle");
	chk_discard_mask:
	assert property (result.valid |-> result.discard ==
		(result.maskMode && result.egressMask == '0))
		else $error("discard not mask mode with empty mask");
	chk_result_hold:
	assert property (!result.valid |->
		$stable(result.egressMask) && $stable(result.discard))
		else $error("result fields moved between results");

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	chk_write_answer:
	assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	chk_read_answer:
	assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	chk_bus_busy:
	assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");

	cover property (take);
	cover property (result.valid && result.discard);
	cover property (result.valid && result.cpuCopy);
	cover property (bvalid && bresp == acl_pkg::RESP_SLVERR);
endmodule : acl_tcam_classifier_props

bind acl_tcam_classifier acl_tcam_classifier_props chk (.clk(clk),
	.rst(rst), .ce(ce), .awvalid(awvalid), .awready(awready),
	.wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bresp(bresp),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid),
	.frameValid(frameValid), .frameReady(frameReady), .result(result));

// *** sim/acl_frame_source.sv ***
// Frame source standing in for the ingress analysis pipeline.
// Assumes send is called right after a rising clk edge.
module acl_frame_source (
	input wire logic clk,
	input wire logic frameReady,
	output logic frameValid,
	output acl_pkg::frame_s frameIn
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Offer
	// ----------------------------------------------------------------
	initial begin
		frameValid = 1'b0;
		frameIn = '0;
	end
	// Hold until taken, then show inverted data so stale keys are useless
	task automatic send(input acl_pkg::frame_s f, input int gap);
		int n;
		repeat (gap) @(posedge clk);
		frameValid <= 1'b1;
		frameIn <= f;
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (frameReady === 1'b1) break;
		end
		frameValid <= 1'b0;
		frameIn <= ~f;
	endtask : send
endmodule : acl_frame_source

// *** sim/acl_tcam_classifier_tb.sv ***
// Self-checking bench of the ACL classifier.
// Assumes the frame source model and the bound port checker.
module acl_tcam_classifier_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, ce;
	logic [15:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, frameValid, frameReady;
	logic [31:0] wdata, rdata, rdv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, resp;
	acl_pkg::frame_s frameIn;
	acl_pkg::result_s result, res;
	int errorCnt, numChecks;

	acl_tcam_classifier #(.NUM_ENTRIES(16)) dut (.clk(clk), .rst(rst),
		.ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready),
		.frameValid(frameValid), .frameIn(frameIn),
		.frameReady(frameReady), .result(result));
	acl_frame_source src (.clk(clk), .frameReady(frameReady),
		.frameValid(frameValid), .frameIn(frameIn));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic ck(input bit ok, input string m);
		numChecks++;
		if (!ok) begin
			errorCnt++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask : ck

	task automatic summarize;
		if (errorCnt == 0 && numChecks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	task automatic hang;
		ck(1'b0, "timeout");
		summarize();
	endtask : hang

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 50) hang();
		resp = bresp;
		bready <= 1'b0;
		wstrb <= 4'hF;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [15:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 50) hang();
		rdv = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask : rd

	task automatic ent(input int i, input logic [31:0] kv, km, c, a);
		logic [15:0] b;
		b = 16'h4000 + 16'(i * 16);
		wr(b, kv);
		wr(b + 16'h0004, km);
		wr(b + 16'h0008, c);
		wr(b + 16'h000C, a);
	endtask : ent

	// Frame with one optional ARP fault, odd ports offered late
	task automatic frm(input logic [3:0] p, input logic [31:0] k, int bad);
		int n;
		acl_pkg::frame_s f;
		f.keyWord = k;
		f.port = p;
		f.dmacBcast = (bad != 1);
		f.arpHwType = (bad == 2) ? 16'h0006 : acl_pkg::ARP_HW_ETH;
		f.arpProtoType = (bad == 3) ? 16'h86DD : acl_pkg::ARP_PROTO_IP;
		f.arpHwLen = (bad == 4) ? 8'h08 : acl_pkg::ARP_HW_LEN;
		f.arpProtoLen = acl_pkg::ARP_PROTO_LEN;
		f.arpSha = 48'h020000000001;
		f.smac = (bad == 5) ? 48'h020000000002 : 48'h020000000001;
		src.send(f, int'(p[0]));
		for (n = 0; n < 20; n++) begin
			@(posedge clk);
			if (result.valid === 1'b1) break;
		end
		if (n == 20) hang();
		res = result;
	endtask : frm

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic sc_regs;
		rd(acl_pkg::DEF2_ACT_OFS);
		ck(rdv === 32'h0 && resp === acl_pkg::RESP_OKAY, "def2 reset");
		rd(acl_pkg::CPU_READY_OFS);
		ck(rdv === 32'h0, "cpu ready reset");
		rd(16'hF000);
		ck(resp === acl_pkg::RESP_SLVERR && rdv === 32'h0, "bad read");
		wr(16'hF000, 32'hFFFFFFFF);
		ck(resp === acl_pkg::RESP_SLVERR, "bad write");
		wr(acl_pkg::DEF2_ACT_OFS, 32'h00000123);
		wstrb <= 4'h2;
		wr(acl_pkg::DEF2_ACT_OFS, 32'hFFFFFFFF);
		rd(acl_pkg::DEF2_ACT_OFS);
		ck(rdv === 32'h0000FF23, "byte lanes");
		wr(acl_pkg::DEF2_ACT_OFS, 32'h0);
	endtask : sc_regs

	task automatic sc_setup;
		wr(16'h010C, 32'h0000015A);
		wr(16'h0110, 32'h00000200);
		wr(16'h0210, 32'h00001000);
		ent(1, 32'hABCD0000, 32'hFFFF0000, 32'hFFF00001, 32'h2D6C0000);
		ent(2, 32'h0, 32'h0, 32'h00800003, 32'h0000100F);
		ent(5, 32'h0, 32'h0, 32'hFFF005AB, 32'h000010F0);
		ent(7, 32'h1234, 32'hFFFF, 32'hFFF00007, 32'h0000103F);
		ent(10, 32'h77, 32'hFF, 32'hFFF00003, 32'h0001B000);
		ent(11, 32'h55, 32'hFF, 32'hFFF00003, 32'h0);
		ent(12, 32'hA0, 32'hFF, 32'hFFF01003, 32'h00001800);
	endtask : sc_setup

	task automatic sc_priority;
		frm(4'h3, 32'h0, 0);
		ck(res.egressMask === 12'h0F0 && res.hit1 === 1'b1, "order");
		ck(res.hit2 === 1'b0 && res.pag === 8'h5A, "port tag");
		ck(res.qosClass === 3'h1, "port class");
		frm(4'h3, 32'h1234, 0);
		ck(res.egressMask === 12'h030 && res.hit2 === 1'b1, "second");
	endtask : sc_priority

	task automatic sc_stage1;
		frm(4'h4, 32'hABCD0000, 0);
		ck(res.pag === 8'h5A && res.hit1 === 1'b1, "tag swap");
		ck(res.qosClass === 3'h5, "class swap");
		frm(4'h4, 32'h0, 0);
		ck(res.discard === 1'b1 && res.hit1 === 1'b0, "port default");
		ck(res.qosClass === 3'h2 && res.pag === 8'h00, "defaults");
	endtask : sc_stage1

	task automatic sc_single_shot;
		frm(4'h0, 32'h77, 0);
		ck(res.cpuCopy === 1'b0 && res.discard === 1'b1, "no ready");
		wr(acl_pkg::CPU_READY_OFS, 32'h1);
		rd(acl_pkg::STATUS_OFS);
		ck(rdv[0] === 1'b1, "ready set");
		frm(4'h0, 32'h77, 0);
		ck(res.cpuCopy === 1'b1 && res.cpuQueue === 3'h3, "copy");
		ck(res.discard === 1'b1, "monitor drop");
		frm(4'h0, 32'h77, 0);
		ck(res.cpuCopy === 1'b0, "single shot");
	endtask : sc_single_shot

	task automatic sc_arp;
		for (int b = 0; b < 6; b++) begin
			frm(4'h0, 32'hA0, b);
			ck(res.hit1 === (b == 0), "arp qualifier");
		end
		frm(4'h0, 32'h55, 0);
		ck(res.hit1 === 1'b1 && res.discard === 1'b0, "zero act");
		ck(res.maskMode === 1'b0 && res.cpuCopy === 1'b0, "zero");
	endtask : sc_arp

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		awaddr = '0;
		araddr = '0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		wdata = '0;
		wstrb = 4'hF;
		errorCnt = 0;
		numChecks = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		sc_regs();
		sc_setup();
		sc_priority();
		sc_stage1();
		sc_single_shot();
		sc_arp();
		summarize();
	end
endmodule : acl_tcam_classifier_tb
